// [rtl/pxb_map.svh]
// constants of the pci-x side transaction path
// included by bare name from the design file
`ifndef PXB_MAP_SVH
`define PXB_MAP_SVH
`define PXB_RQ_DEPTH 6
`define PXB_WCMD_DEPTH 40
`define PXB_DQ_BYTES 4096
`define PXB_WORD_BYTES 8
`define PXB_VME_WSETS 2
`define PXB_LNK_PORTS 5
`define PXB_ADDR32_TOP 32
`endif

// [rtl/pxb_path.sv]
// pci-x target read/write path, completion master and linkage arbiter
// assumes one clock mclk_i; all inputs synchronous to it
//
// Summary of operation
// - every accepted read split, six outstanding
// - store request, then answer split response
// - one queue entry per accepted read
// - read queue full gives retry
// - one linkage read for whole count
// - linkage ports served round robin
// - vme returns only complete byte counts
// - completion starts once all data queued
// - past window end: truncate, completion error
// - writes posted, acknowledged at once
// - full write buffer gives retry
// - 40 commands, 4 Kbyte write data
// - write forwarded after pci-x transfer ends
// - window end: accept up to end, disconnect
// - burst filling buffer is disconnected
// - two vme write sets outstanding
// - split completion, dac above 32 bits
// - six-entry read queue, 4 Kbyte data
// - request bus, return completed data
// - write full when either queue full
// - keep bus until done or timer out
// - request bus while work remains
// - reads wait for posted writes flushed
// - window hit inclusive, window zero first
`timescale 1ns/10ps
`include "pxb_map.svh"

module pxb_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	logic [W-1:0] mem [D];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic push;
	logic pop;
	assign in_ready_o = cnt_r != CW'(D);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem[rp_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem[wp_r] <= in_data_i;
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == PW'(D - 1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == PW'(D - 1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + CW'(push) - CW'(pop);
		end
	end
endmodule : pxb_fifo

module pxb_path #(
	parameter int AW = 64,
	parameter int DW = 64,
	parameter int TW = 8,
	parameter int NWIN = 8,
	parameter int RQD = `PXB_RQ_DEPTH,
	parameter int WCMD = `PXB_WCMD_DEPTH,
	parameter int WDQ = `PXB_DQ_BYTES / `PXB_WORD_BYTES,
	parameter int RDQ = `PXB_DQ_BYTES / `PXB_WORD_BYTES,
	parameter int WSETS = `PXB_VME_WSETS,
	parameter int NPORT = `PXB_LNK_PORTS
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// mapping windows
	input wire logic [NWIN-1:0] win_en_i,
	input wire logic [NWIN-1:0][AW-1:0] win_start_i,
	input wire logic [NWIN-1:0][AW-1:0] win_end_i,
	input wire logic [NWIN-1:0][AW-1:0] win_off_i,
	// pci-x target request and beats
	input wire logic tq_valid_i,
	input wire logic tq_read_i,
	input wire logic [AW-1:0] tq_addr_i,
	input wire logic [12:0] tq_bcnt_i,
	input wire logic [TW-1:0] tq_tag_i,
	input wire logic td_valid_i,
	input wire logic [DW-1:0] td_data_i,
	input wire logic td_last_i,
	output pxb_pkg::pxb_term_t tq_term_o,
	// posted write stream to linkage
	output logic lw_valid_o,
	output logic lw_trail_o,
	output logic [DW-1:0] lw_data_o,
	output logic [$clog2(WDQ+1)-1:0] lw_cnt_o,
	input wire logic lw_ready_i,
	input wire logic lw_done_i,
	// read command to linkage and returned data
	output logic lr_valid_o,
	output logic [AW-1:0] lr_addr_o,
	output logic [12:0] lr_bcnt_o,
	input wire logic lr_ready_i,
	input wire logic rd_valid_i,
	input wire logic [DW-1:0] rd_data_i,
	// pci-x master split completion
	output logic mst_req_o,
	output logic mst_own_o,
	output pxb_pkg::pxb_mcmd_t mst_cmd_o,
	output logic mst_dac_o,
	input wire logic mst_gnt_i,
	input wire logic [7:0] lat_timer_i,
	output logic sc_valid_o,
	output logic [DW-1:0] sc_data_o,
	output logic sc_last_o,
	output logic sc_err_o,
	output logic [TW-1:0] sc_tag_o,
	output logic [12:0] sc_bcnt_o,
	// linkage arbiter
	input wire logic [NPORT-1:0] arb_req_i,
	output logic [NPORT-1:0] arb_gnt_o
);
	localparam int BCW = 13;
	localparam int RQW = $clog2(RQD);
	localparam int RDA = $clog2(RDQ);
	localparam int RDW = RDA + 1;
	localparam int WCW = $clog2(WDQ + 1);
	localparam int CMW = $clog2(WCMD + 1);
	localparam int CRW = $clog2(WSETS + 1);
	localparam int PTW = $clog2(NPORT);
	localparam int FW = 1 + WCW + DW;

	function automatic logic [RDW-1:0] words(input logic [BCW-1:0] b);
		logic [BCW:0] t;
		t = {1'b0, b} + (BCW + 1)'(7);
		return RDW'(t >> 3);
	endfunction : words

	function automatic logic [RQW-1:0] rinc(input logic [RQW-1:0] p);
		return (p == RQW'(RQD - 1)) ? '0 : p + 1'b1;
	endfunction : rinc

	// window decode
	logic [NWIN-1:0] hit_v;
	logic hit;
	logic [AW-1:0] sel_end;
	logic [AW-1:0] sel_off;
	logic [AW-1:0] xaddr;
	logic [AW-1:0] lim;
	logic trunc;
	logic [BCW-1:0] rbcnt;
	genvar gi;
	generate
		for (gi = 0; gi < NWIN; gi++)
		begin : g_win
			assign hit_v[gi] = win_en_i[gi] && tq_addr_i >= win_start_i[gi]
				&& tq_addr_i <= win_end_i[gi];
		end
	endgenerate
	always_comb
	begin
		hit = 1'b0;
		sel_end = '0;
		sel_off = '0;
		for (int i = NWIN - 1; i >= 0; i--)
		begin
			if (hit_v[i])
			begin
				hit = 1'b1;
				sel_end = win_end_i[i];
				sel_off = win_off_i[i];
			end
		end
	end
	assign xaddr = tq_addr_i + sel_off;
	assign lim = sel_end - tq_addr_i + AW'(1);
	assign trunc = lim < AW'(tq_bcnt_i);
	assign rbcnt = trunc ? lim[BCW-1:0] : tq_bcnt_i;

	// target decode
	logic [RQW:0] rq_cnt_r;
	logic [RQW:0] rq_pend_r;
	logic [WCW-1:0] wocc_r;
	logic [CMW-1:0] wcmd_r;
	logic wr_act_r;
	logic wr_trail_r;
	logic [AW-1:0] wr_left_r;
	logic [AW-1:0] wr_addr_r;
	logic [WCW-1:0] wr_words_r;
	logic rq_full;
	logic wr_full;
	logic rd_req;
	logic rd_acc;
	logic wr_req;
	logic wr_go;
	logic bt;
	logic disc;
	logic f_in_rdy;
	assign rq_full = rq_cnt_r == (RQW + 1)'(RQD);
	assign wr_full = wocc_r >= WCW'(WDQ - 1) || wcmd_r == CMW'(WCMD);
	assign rd_req = tq_valid_i && tq_read_i && hit;
	assign rd_acc = rd_req && !rq_full;
	assign wr_req = tq_valid_i && !tq_read_i && hit && !wr_act_r
		&& !wr_trail_r;
	assign wr_go = wr_req && !wr_full;
	assign bt = td_valid_i && wr_act_r && f_in_rdy;
	assign disc = !td_last_i && (wr_left_r == AW'(1)
		|| wocc_r == WCW'(WDQ - 2));
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			tq_term_o <= pxb_pkg::TERM_NONE;
		else if (rd_req)
			tq_term_o <= rq_full ? pxb_pkg::TERM_RETRY
				: pxb_pkg::TERM_SPLIT;
		else if (wr_req && wr_full)
			tq_term_o <= pxb_pkg::TERM_RETRY;
		else if (bt)
			tq_term_o <= disc ? pxb_pkg::TERM_DISC
				: pxb_pkg::TERM_ACCEPT;
		else
			tq_term_o <= pxb_pkg::TERM_NONE;
	end

	// posted write capture
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_act_r <= 1'b0;
			wr_trail_r <= 1'b0;
			wr_left_r <= '0;
			wr_addr_r <= '0;
			wr_words_r <= '0;
		end
		else
		begin
			if (wr_go)
			begin
				wr_act_r <= 1'b1;
				wr_addr_r <= xaddr;
				wr_left_r <= lim >> 3;
				wr_words_r <= '0;
			end
			else if (bt)
			begin
				wr_words_r <= wr_words_r + 1'b1;
				wr_left_r <= wr_left_r - AW'(1);
				if (td_last_i || disc)
				begin
					wr_act_r <= 1'b0;
					wr_trail_r <= 1'b1;
				end
			end
			if (wr_trail_r && f_in_rdy)
				wr_trail_r <= 1'b0;
		end
	end

	// write data queue and linkage stage
	logic f_in_valid;
	logic [FW-1:0] f_in_data;
	logic f_out_valid;
	logic [FW-1:0] f_out_data;
	logic pop;
	logic head_tr;
	logic tpush;
	logic [CMW-1:0] wcmt_r;
	logic [CRW-1:0] vcred_r;
	assign f_in_valid = (td_valid_i && wr_act_r) || wr_trail_r;
	assign f_in_data = wr_trail_r ? {1'b1, wr_words_r, DW'(wr_addr_r)}
		: {1'b0, WCW'(0), td_data_i};
	assign tpush = wr_trail_r && f_in_rdy;
	assign head_tr = f_out_data[FW-1];
	assign pop = f_out_valid && wcmt_r != '0 && (!lw_valid_o || lw_ready_i)
		&& (!head_tr || vcred_r != '0);
	pxb_fifo #(.W(FW), .D(WDQ)) u_wdq (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.in_valid_i(f_in_valid),
		.in_data_i(f_in_data),
		.in_ready_o(f_in_rdy),
		.out_valid_o(f_out_valid),
		.out_data_o(f_out_data),
		.out_ready_i(pop)
	);
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wocc_r <= '0;
			wcmd_r <= '0;
			wcmt_r <= '0;
			vcred_r <= CRW'(WSETS);
		end
		else
		begin
			wocc_r <= wocc_r + WCW'(f_in_valid && f_in_rdy) - WCW'(pop);
			wcmd_r <= wcmd_r + CMW'(wr_go) - CMW'(pop && head_tr);
			wcmt_r <= wcmt_r + CMW'(tpush) - CMW'(pop && head_tr);
			vcred_r <= vcred_r + CRW'(lw_done_i)
				- CRW'(pop && head_tr);
		end
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			lw_valid_o <= 1'b0;
			lw_trail_o <= 1'b0;
			lw_data_o <= '0;
			lw_cnt_o <= '0;
		end
		else if (!lw_valid_o || lw_ready_i)
		begin
			lw_valid_o <= pop;
			lw_trail_o <= pop && head_tr;
			lw_data_o <= f_out_data[DW-1:0];
			lw_cnt_o <= f_out_data[DW+:WCW];
		end
	end

	// read command queue
	logic [AW-1:0] rq_addr [RQD];
	logic [BCW-1:0] rq_bcnt [RQD];
	logic [TW-1:0] rq_tag [RQD];
	logic rq_err [RQD];
	logic [RQW-1:0] rq_wp_r;
	logic [RQW-1:0] rq_ip_r;
	logic [RQW-1:0] rq_cp_r;
	logic [RDW-1:0] rsv_r;
	logic [RDW-1:0] iw;
	logic flushed;
	logic iss;
	logic sc_pop;
	logic [RDW-1:0] hw;
	always_ff @(posedge mclk_i)
	begin
		if (rd_acc)
		begin
			rq_addr[rq_wp_r] <= xaddr;
			rq_bcnt[rq_wp_r] <= rbcnt;
			rq_tag[rq_wp_r] <= tq_tag_i;
			rq_err[rq_wp_r] <= trunc;
		end
	end
	assign iw = words(rq_bcnt[rq_ip_r]);
	assign hw = words(rq_bcnt[rq_cp_r]);
	assign flushed = wcmd_r == '0 && !lw_valid_o
		&& vcred_r == CRW'(WSETS);
	assign iss = rq_pend_r != '0 && (!lr_valid_o || lr_ready_i) && flushed
		&& ({1'b0, rsv_r} + {1'b0, iw}) <= (RDW + 1)'(RDQ);
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rq_wp_r <= '0;
			rq_ip_r <= '0;
			rq_cp_r <= '0;
			rq_cnt_r <= '0;
			rq_pend_r <= '0;
			rsv_r <= '0;
		end
		else
		begin
			if (rd_acc)
				rq_wp_r <= rinc(rq_wp_r);
			if (iss)
				rq_ip_r <= rinc(rq_ip_r);
			if (sc_pop)
				rq_cp_r <= rinc(rq_cp_r);
			rq_cnt_r <= rq_cnt_r + (RQW + 1)'(rd_acc)
				- (RQW + 1)'(sc_pop);
			rq_pend_r <= rq_pend_r + (RQW + 1)'(rd_acc)
				- (RQW + 1)'(iss);
			rsv_r <= rsv_r + (iss ? iw : '0) - (sc_pop ? hw : '0);
		end
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			lr_valid_o <= 1'b0;
			lr_addr_o <= '0;
			lr_bcnt_o <= '0;
		end
		else if (!lr_valid_o || lr_ready_i)
		begin
			lr_valid_o <= iss;
			lr_addr_o <= rq_addr[rq_ip_r];
			lr_bcnt_o <= rq_bcnt[rq_ip_r];
		end
	end

	// read data queue, filled whole counts in issue order
	logic [DW-1:0] rdq [RDQ];
	logic [RDA-1:0] rdq_wp_r;
	logic [RDA-1:0] rdq_rp_r;
	logic [RDW-1:0] rdq_cnt_r;
	logic beat;
	always_ff @(posedge mclk_i)
	begin
		if (rd_valid_i)
			rdq[rdq_wp_r] <= rd_data_i;
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rdq_wp_r <= '0;
			rdq_rp_r <= '0;
			rdq_cnt_r <= '0;
		end
		else
		begin
			if (rd_valid_i)
				rdq_wp_r <= rdq_wp_r + 1'b1;
			if (beat)
				rdq_rp_r <= rdq_rp_r + 1'b1;
			rdq_cnt_r <= rdq_cnt_r + RDW'(rd_valid_i) - RDW'(beat);
		end
	end

	// split completion master
	pxb_pkg::pxb_sc_t sc_r;
	pxb_pkg::pxb_sc_t sc_nxt;
	logic [RDW-1:0] left_r;
	logic [7:0] lat_r;
	logic lat_out;
	assign beat = sc_r == pxb_pkg::SC_DATA;
	assign sc_pop = beat && left_r == RDW'(1);
	assign lat_out = !mst_gnt_i && lat_r >= lat_timer_i;
	always_comb
	begin
		sc_nxt = sc_r;
		case (sc_r)
			pxb_pkg::SC_IDLE:
				if (rq_cnt_r != rq_pend_r && rdq_cnt_r >= hw)
					sc_nxt = pxb_pkg::SC_REQ;
			pxb_pkg::SC_REQ:
				if (mst_gnt_i)
					sc_nxt = pxb_pkg::SC_DATA;
			pxb_pkg::SC_DATA:
				if (sc_pop)
					sc_nxt = pxb_pkg::SC_IDLE;
				else if (lat_out)
					sc_nxt = pxb_pkg::SC_REQ;
			default:
				sc_nxt = pxb_pkg::SC_IDLE;
		endcase
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sc_r <= pxb_pkg::SC_IDLE;
			left_r <= '0;
			lat_r <= '0;
		end
		else
		begin
			sc_r <= sc_nxt;
			if (sc_r == pxb_pkg::SC_IDLE)
				left_r <= hw;
			else if (beat)
				left_r <= left_r - RDW'(1);
			if (!beat)
				lat_r <= '0;
			else if (lat_r != 8'hff)
				lat_r <= lat_r + 8'h01;
		end
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mst_req_o <= 1'b0;
			mst_own_o <= 1'b0;
			mst_cmd_o <= pxb_pkg::MC_IDLE;
			mst_dac_o <= 1'b0;
			sc_valid_o <= 1'b0;
			sc_data_o <= '0;
			sc_last_o <= 1'b0;
			sc_err_o <= 1'b0;
			sc_tag_o <= '0;
			sc_bcnt_o <= '0;
		end
		else
		begin
			mst_req_o <= sc_nxt == pxb_pkg::SC_REQ;
			mst_own_o <= beat;
			mst_cmd_o <= beat ? pxb_pkg::MC_SPLIT_CPL
				: pxb_pkg::MC_IDLE;
			mst_dac_o <= beat
				&& rq_addr[rq_cp_r][AW-1:`PXB_ADDR32_TOP] != '0;
			sc_valid_o <= beat;
			sc_data_o <= rdq[rdq_rp_r];
			sc_last_o <= sc_pop;
			sc_err_o <= sc_pop && rq_err[rq_cp_r];
			sc_tag_o <= rq_tag[rq_cp_r];
			sc_bcnt_o <= rq_bcnt[rq_cp_r];
		end
	end

	// linkage round robin
	logic [NPORT-1:0] gnt_n;
	logic [PTW-1:0] last_r;
	logic [PTW-1:0] win_n;
	logic found;
	always_comb
	begin
		gnt_n = '0;
		win_n = last_r;
		found = 1'b0;
		for (int k = 1; k <= NPORT; k++)
		begin
			if (!found && arb_req_i[(int'(last_r) + k) % NPORT])
			begin
				found = 1'b1;
				win_n = PTW'((int'(last_r) + k) % NPORT);
				gnt_n[(int'(last_r) + k) % NPORT] = 1'b1;
			end
		end
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			arb_gnt_o <= '0;
			last_r <= PTW'(NPORT - 1);
		end
		else
		begin
			arb_gnt_o <= gnt_n;
			last_r <= win_n;
		end
	end

	property p_rd_retry;
		@(posedge mclk_i) disable iff (!nrst_i)
		rd_req && rq_full |=> tq_term_o == pxb_pkg::TERM_RETRY;
	endproperty
	a_rd_retry: assert property (p_rd_retry)
		else $error("read not retried when queue full");
	property p_rd_split;
		@(posedge mclk_i) disable iff (!nrst_i)
		rd_acc |=> tq_term_o == pxb_pkg::TERM_SPLIT && rq_cnt_r != '0;
	endproperty
	a_rd_split: assert property (p_rd_split)
		else $error("accepted read not split");
	property p_rq_max;
		@(posedge mclk_i) disable iff (!nrst_i)
		rq_cnt_r <= (RQW + 1)'(RQD) && rq_pend_r <= rq_cnt_r;
	endproperty
	a_rq_max: assert property (p_rq_max)
		else $error("read queue over six");
	property p_wr_retry;
		@(posedge mclk_i) disable iff (!nrst_i)
		wr_req && wr_full |=> tq_term_o == pxb_pkg::TERM_RETRY && !wr_act_r;
	endproperty
	a_wr_retry: assert property (p_wr_retry)
		else $error("write not retried when full");
	property p_win_disc;
		@(posedge mclk_i) disable iff (!nrst_i)
		bt && !td_last_i && wr_left_r == AW'(1)
		|=> tq_term_o == pxb_pkg::TERM_DISC && wr_trail_r && !wr_act_r;
	endproperty
	a_win_disc: assert property (p_win_disc)
		else $error("no disconnect at window end");
	property p_flush;
		@(posedge mclk_i) disable iff (!nrst_i)
		$rose(lr_valid_o) |-> $past(wcmd_r) == '0;
	endproperty
	a_flush: assert property (p_flush)
		else $error("read issued before writes flushed");
	property p_commit;
		@(posedge mclk_i) disable iff (!nrst_i)
		$rose(lw_valid_o) |-> $past(wcmt_r) != '0;
	endproperty
	a_commit: assert property (p_commit)
		else $error("write data forwarded before transfer end");
	property p_sc_full;
		@(posedge mclk_i) disable iff (!nrst_i)
		sc_r != pxb_pkg::SC_IDLE |-> rdq_cnt_r >= left_r;
	endproperty
	a_sc_full: assert property (p_sc_full)
		else $error("completion started without all data");
	property p_own;
		@(posedge mclk_i) disable iff (!nrst_i)
		beat && !sc_pop && lat_out |=> sc_r == pxb_pkg::SC_REQ && mst_req_o;
	endproperty
	a_own: assert property (p_own)
		else $error("bus kept after latency expiry");
	property p_arb;
		@(posedge mclk_i) disable iff (!nrst_i)
		|arb_req_i |=> |arb_gnt_o;
	endproperty
	a_arb: assert property (p_arb)
		else $error("linkage grant missing");
	property p_arb_one;
		@(posedge mclk_i) disable iff (!nrst_i)
		$onehot0(arb_gnt_o);
	endproperty
	a_arb_one: assert property (p_arb_one)
		else $error("linkage grant not one-hot");
endmodule : pxb_path

// [rtl/pxb_pkg.sv]
// types of the pci-x side transaction path
// no other package is needed
package pxb_pkg;
	typedef enum logic [2:0] {TERM_NONE, TERM_SPLIT, TERM_ACCEPT,
		TERM_RETRY, TERM_DISC} pxb_term_t;
	typedef enum logic [1:0] {MC_IDLE, MC_SPLIT_CPL, MC_MRD_BLK,
		MC_MWR_BLK} pxb_mcmd_t;
	typedef enum logic [1:0] {SC_IDLE, SC_REQ, SC_DATA} pxb_sc_t;
endpackage : pxb_pkg

// [sim/pxb_far_model.sv]
// far side model: linkage with the vme master behind pxb_path
// assumes pxb_path drives its inputs; stall_i from the bench slows answers
`timescale 1ns/10ps
module pxb_far_model (
	// clock, reset, slow answers
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic stall_i,
	// posted write stream
	input wire logic lw_valid_i,
	input wire logic lw_trail_i,
	input wire logic [63:0] lw_data_i,
	input wire logic [9:0] lw_cnt_i,
	output logic lw_ready_o,
	output logic lw_done_o,
	// read command and returned words
	input wire logic lr_valid_i,
	input wire logic [63:0] lr_addr_i,
	input wire logic [12:0] lr_bcnt_i,
	output logic lr_ready_o,
	output logic rd_valid_o,
	output logic [63:0] rd_data_o,
	// observation
	output int trails_o,
	output int dones_o,
	output int reads_o,
	output logic [63:0] t_addr_o,
	output logic [9:0] t_cnt_o,
	output logic [63:0] r_addr_o,
	output logic [12:0] r_bcnt_o
);
	logic take_w;
	logic take_r;
	logic [63:0] base;
	int pend;
	int tmr;
	int left;
	assign take_w = lw_valid_i && lw_ready_o;
	assign take_r = lr_valid_i && lr_ready_o;
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			lw_ready_o <= 1'b0;
			lw_done_o <= 1'b0;
			lr_ready_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 64'h0;
			base <= 64'h0;
			{trails_o, dones_o, reads_o, pend, tmr, left} <= '0;
			{t_addr_o, t_cnt_o, r_addr_o, r_bcnt_o} <= '0;
		end
		else
		begin
			lw_ready_o <= !stall_i;
			if (take_w && lw_trail_i)
			begin
				trails_o <= trails_o + 1;
				t_addr_o <= lw_data_i;
				t_cnt_o <= lw_cnt_i;
			end
			// two write sets held, retired one at a time
			pend <= pend + int'(take_w && lw_trail_i) - int'(tmr == 4);
			tmr <= (pend > 0 && tmr < 4) ? tmr + 1 : 0;
			lw_done_o <= (tmr == 4);
			dones_o <= dones_o + int'(tmr == 4);
			lr_ready_o <= !stall_i && left == 0 && !take_r;
			if (take_r)
			begin
				reads_o <= reads_o + 1;
				r_addr_o <= lr_addr_i;
				r_bcnt_o <= lr_bcnt_i;
				base <= lr_addr_i;
				left <= (int'(lr_bcnt_i) + 7) / 8;
				rd_valid_o <= 1'b0;
				rd_data_o <= ~rd_data_o;
			end
			else if (left > 0)
			begin
				// whole count returned word after word
				rd_valid_o <= 1'b1;
				rd_data_o <= base;
				base <= base + 64'h1;
				left <= left - 1;
			end
			else
			begin
				rd_valid_o <= 1'b0;
				rd_data_o <= ~rd_data_o;
			end
		end
	end
endmodule : pxb_far_model

// [sim/test_pcix_split_read_posted_write_path.sv]
// self-checking bench for pxb_path with the far side model
// assumes rtl/pxb_pkg.sv and rtl/pxb_path.sv are compiled first
`timescale 1ns/10ps
module test_pcix_split_read_posted_write_path;
	logic mclk_i, nrst_i, stall;
	logic [7:0] win_en_i;
	logic [7:0][63:0] win_start_i, win_end_i, win_off_i;
	logic tq_valid_i, tq_read_i, td_valid_i, td_last_i;
	logic [63:0] tq_addr_i, td_data_i, lw_data_o, lr_addr_o, rd_data_i;
	logic [12:0] tq_bcnt_i, lr_bcnt_o, sc_bcnt_o, l_bcnt, r_bcnt;
	logic [7:0] tq_tag_i, sc_tag_o, lat_timer_i, l_tag;
	pxb_pkg::pxb_term_t tq_term_o, seen;
	pxb_pkg::pxb_mcmd_t mst_cmd_o;
	logic lw_valid_o, lw_trail_o, lw_ready_i, lw_done_i, lr_valid_o;
	logic lr_ready_i, rd_valid_i, mst_req_o, mst_own_o, mst_dac_o, mst_gnt_i;
	logic sc_valid_o, sc_last_o, sc_err_o, l_err, hi;
	logic [9:0] lw_cnt_o, t_cnt;
	logic [63:0] sc_data_o, sc_first, t_addr, r_addr;
	logic [4:0] arb_req_i, arb_gnt_o;
	int errors, checks_done, sc_words, sc_lasts, trails, dones, reads;

	pxb_path dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .win_en_i(win_en_i),
		.win_start_i(win_start_i), .win_end_i(win_end_i),
		.win_off_i(win_off_i), .tq_valid_i(tq_valid_i),
		.tq_read_i(tq_read_i), .tq_addr_i(tq_addr_i), .tq_bcnt_i(tq_bcnt_i),
		.tq_tag_i(tq_tag_i), .td_valid_i(td_valid_i), .td_data_i(td_data_i),
		.td_last_i(td_last_i), .tq_term_o(tq_term_o),
		.lw_valid_o(lw_valid_o), .lw_trail_o(lw_trail_o),
		.lw_data_o(lw_data_o), .lw_cnt_o(lw_cnt_o), .lw_ready_i(lw_ready_i),
		.lw_done_i(lw_done_i), .lr_valid_o(lr_valid_o),
		.lr_addr_o(lr_addr_o), .lr_bcnt_o(lr_bcnt_o),
		.lr_ready_i(lr_ready_i), .rd_valid_i(rd_valid_i),
		.rd_data_i(rd_data_i), .mst_req_o(mst_req_o), .mst_own_o(mst_own_o),
		.mst_cmd_o(mst_cmd_o), .mst_dac_o(mst_dac_o), .mst_gnt_i(mst_gnt_i),
		.lat_timer_i(lat_timer_i), .sc_valid_o(sc_valid_o),
		.sc_data_o(sc_data_o), .sc_last_o(sc_last_o), .sc_err_o(sc_err_o),
		.sc_tag_o(sc_tag_o), .sc_bcnt_o(sc_bcnt_o), .arb_req_i(arb_req_i),
		.arb_gnt_o(arb_gnt_o));

	pxb_far_model far_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .stall_i(stall),
		.lw_valid_i(lw_valid_o), .lw_trail_i(lw_trail_o),
		.lw_data_i(lw_data_o), .lw_cnt_i(lw_cnt_o), .lw_ready_o(lw_ready_i),
		.lw_done_o(lw_done_i), .lr_valid_i(lr_valid_o),
		.lr_addr_i(lr_addr_o), .lr_bcnt_i(lr_bcnt_o),
		.lr_ready_o(lr_ready_i), .rd_valid_o(rd_valid_i),
		.rd_data_o(rd_data_i), .trails_o(trails), .dones_o(dones),
		.reads_o(reads), .t_addr_o(t_addr), .t_cnt_o(t_cnt),
		.r_addr_o(r_addr), .r_bcnt_o(r_bcnt));

	task chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	task report_and_stop;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	// last termination and completion words seen
	always @(posedge mclk_i)
	begin
		if (tq_term_o !== pxb_pkg::TERM_NONE)
			seen = tq_term_o;
		if (sc_valid_o === 1'b1)
		begin
			chk(mst_cmd_o === pxb_pkg::MC_SPLIT_CPL, "command");
			chk(mst_dac_o === hi, "dual address cycle");
			if (sc_words == 0)
				sc_first = sc_data_o;
			sc_words++;
			if (sc_last_o === 1'b1)
			begin
				sc_lasts++;
				{l_tag, l_bcnt, l_err} = {sc_tag_o, sc_bcnt_o, sc_err_o};
			end
		end
		if (lr_valid_o === 1'b1 && lr_ready_i === 1'b1)
			chk(dones == trails, "read before writes drained");
	end

	task req(input logic rd, input logic [63:0] a, input logic [12:0] bc,
		input logic [7:0] tg);
		@(negedge mclk_i);
		seen = pxb_pkg::TERM_NONE;
		{tq_valid_i, tq_read_i, tq_addr_i, tq_bcnt_i} = {1'b1, rd, a, bc};
		tq_tag_i = tg;
		@(negedge mclk_i);
		tq_valid_i = 1'b0;
	endtask : req

	task wr(input logic [63:0] a, input int n);
		req(1'b0, a, 13'(n * 8), 8'h00);
		for (int i = 0; i < n; i++)
		begin
			if (i > 0)
				@(negedge mclk_i);
			{td_valid_i, td_data_i} = {1'b1, a + 64'(i)};
			td_last_i = (i == n - 1);
		end
		@(negedge mclk_i);
		{td_valid_i, td_last_i} = 2'b00;
		repeat (3) @(negedge mclk_i);
	endtask : wr

	task rd(input logic [63:0] a, input logic [12:0] bc, input logic [7:0] tg,
		input logic [12:0] xb, input logic xe);
		int r0, c0;
		{r0, c0, sc_words} = {reads, sc_lasts, 32'h0};
		req(1'b1, a, bc, tg);
		repeat (2) @(negedge mclk_i);
		chk(seen === pxb_pkg::TERM_SPLIT, "split response");
		for (int k = 0; k < 300 && reads == r0; k++) @(negedge mclk_i);
		chk(r_addr === a + 64'h100000, "read command address");
		chk(r_bcnt === xb, "read command count");
		for (int k = 0; k < 300 && mst_req_o !== 1'b1; k++) @(negedge mclk_i);
		chk(mst_req_o === 1'b1, "bus request");
		mst_gnt_i = 1'b1;
		for (int k = 0; k < 300 && sc_lasts == c0; k++) @(negedge mclk_i);
		mst_gnt_i = 1'b0;
		chk(sc_words == (int'(xb) + 7) / 8, "completion words");
		chk(sc_first === a + 64'h100000, "completion data");
		chk(l_tag === tg && l_bcnt === xb, "completion tag or count");
		chk(l_err === xe, "completion error flag");
	endtask : rd

	task s_arb;
		int p, q, g;
		p = -1;
		g = 0;
		@(negedge mclk_i);
		arb_req_i = 5'h1f;
		repeat (12)
		begin
			@(negedge mclk_i);
			if (arb_gnt_o !== 5'h00)
			begin
				for (int k = 0; k < 5; k++) if (arb_gnt_o[k]) q = k;
				chk($onehot(arb_gnt_o), "grant not one-hot");
				if (p >= 0)
					chk(q == (p + 1) % 5, "grant order");
				{p, g} = {q, g + 1};
			end
		end
		arb_req_i = 5'h00;
		chk(g >= 5, "too few grants");
	endtask : s_arb

	task s_wr_rd;
		wr(64'h1000, 4);
		chk(seen === pxb_pkg::TERM_ACCEPT, "write not accepted");
		rd(64'h1100, 13'h20, 8'h05, 13'h20, 1'b0);
		chk(t_cnt === 10'h4, "trailer count");
		chk(t_addr === 64'h101000, "window zero offset");
		wr(64'h1ff0, 3);
		chk(seen === pxb_pkg::TERM_DISC, "window end disconnect");
		repeat (20) @(negedge mclk_i);
		chk(t_cnt === 10'h2, "words up to window end");
		rd(64'h1ff0, 13'h40, 8'h07, 13'h10, 1'b1);
	endtask : s_wr_rd

	task s_six;
		int c0;
		{c0, stall} = {sc_lasts, 1'b1};
		for (int i = 0; i < 7; i++)
		begin
			req(1'b1, 64'h1200 + 64'(i * 64), 13'h8, 8'(i));
			repeat (2) @(negedge mclk_i);
			if (i < 6)
				chk(seen === pxb_pkg::TERM_SPLIT, "split while queueing");
			else
				chk(seen === pxb_pkg::TERM_RETRY, "retry when full");
		end
		{stall, mst_gnt_i} = 2'b01;
		for (int k = 0; k < 3000 && sc_lasts < c0 + 6; k++) @(negedge mclk_i);
		mst_gnt_i = 1'b0;
		chk(sc_lasts == c0 + 6, "six completions");
	endtask : s_six

	task s_lat;
		int c0;
		{c0, hi} = {sc_lasts, 1'b1};
		req(1'b1, 64'h4000, 13'h100, 8'h09);
		for (int k = 0; k < 300 && mst_req_o !== 1'b1; k++) @(negedge mclk_i);
		mst_gnt_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		mst_gnt_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		chk(mst_own_o === 1'b1, "bus left before timer out");
		repeat (20) @(negedge mclk_i);
		chk(mst_own_o === 1'b0, "bus kept after timer out");
		chk(mst_req_o === 1'b1, "no request for unfinished work");
		mst_gnt_i = 1'b1;
		for (int k = 0; k < 300 && sc_lasts == c0; k++) @(negedge mclk_i);
		mst_gnt_i = 1'b0;
		chk(l_tag === 8'h09 && l_bcnt === 13'h100, "resumed completion");
		chk(r_addr === 64'h100004000, "high window address");
	endtask : s_lat

	initial
	begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	initial
	begin
		#600000;
		errors++;
		report_and_stop;
	end

	initial
	begin
		{errors, checks_done, sc_words, sc_lasts} = '0;
		{nrst_i, stall, tq_valid_i, tq_read_i, td_valid_i} = '0;
		{td_last_i, mst_gnt_i, tq_addr_i, td_data_i, tq_bcnt_i} = '0;
		{tq_tag_i, arb_req_i, lat_timer_i} = {8'h00, 5'h00, 8'h10};
		{win_start_i, win_end_i, win_off_i} = '0;
		// window one overlaps window zero with another offset
		win_en_i = 8'h07;
		hi = 1'b0;
		{win_start_i[0], win_end_i[0], win_off_i[0]} =
			{64'h1000, 64'h1fff, 64'h100000};
		{win_start_i[1], win_end_i[1], win_off_i[1]} =
			{64'h1000, 64'h1fff, 64'h200000};
		// window two maps above the 32-bit range
		{win_start_i[2], win_end_i[2], win_off_i[2]} =
			{64'h4000, 64'h4fff, 64'h100000000};
		repeat (2) @(negedge mclk_i);
		nrst_i = 1'b1;
		@(negedge mclk_i);
		chk(tq_term_o === pxb_pkg::TERM_NONE && lw_valid_o === 1'b0 &&
			mst_req_o === 1'b0 && arb_gnt_o === 5'h00, "reset outputs");
		s_arb;
		s_wr_rd;
		s_six;
		s_lat;
		report_and_stop;
	end
endmodule : test_pcix_split_read_posted_write_path
